// ### hdl/drb_pkg.sv
// Shared constants and types for the drive register bridge and data buffer.
`default_nettype none
package drb_pkg;

  // Controller clock period and the settle times derived from it.
  localparam int CLK_PERIOD_NS = 100;
  localparam int SETTLE_NS = 235;
  localparam int READ_HOLD_NS = 220;
  // Least times round up to whole cycles.
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_HOLD_CYC =
    (READ_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 4;

  // Word indices of the onboard registers on the Avalon bus.
  localparam logic [4:0] IDX_CS2 = 5'h04;
  localparam logic [4:0] IDX_DB = 5'h05;
  localparam logic [4:0] IDX_DB_DOUBLE = 5'h06;

  // Coded bits that pick one onboard register.
  localparam logic [1:0] CODE_CS2 = 2'h0;
  localparam logic [1:0] CODE_DB = 2'h1;
  localparam logic [1:0] CODE_DB_DOUBLE = 2'h2;
  localparam logic [1:0] CODE_NONE = 2'h3;

  // Field layout of control_status_two.
  localparam int CS2_UNIT_LSB = 0;
  localparam int CS2_UNIT_W = 3;
  localparam int CS2_FLUSH_BIT = 5;
  localparam int CS2_IR_BIT = 6;
  localparam int CS2_OR_BIT = 7;
  localparam logic [2:0] CS2_UNIT_RST = 3'h0;

  // Stage numbers inside the data_buffer.
  localparam int STG_IN_EVEN = 0;
  localparam int STG_IN_ODD = 1;
  localparam int STG_MID_EVEN = 2;
  localparam int STG_MID_ODD = 3;
  localparam int STG_MERGE = 4;
  localparam int STG_RIPPLE1 = 5;
  localparam int STG_RIPPLE2 = 6;
  localparam int STG_OUT = 7;
  localparam int STAGES = 8;

  // Host cycle kinds as decoded from the bus control lines.
  typedef enum logic [1:0] {
    CYC_READ = 2'h0,
    CYC_READ_PAUSE = 2'h1,
    CYC_WRITE = 2'h2
  } drb_cycle_e;

  // Register access sequencer states, one-hot.
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_SETTLE = 6'h02,
    ST_DRIVE_WAIT = 6'h04,
    ST_READ_HOLD = 6'h08,
    ST_DONE = 6'h10,
    ST_RELEASE = 6'h20
  } drb_state_e;

endpackage
`default_nettype wire

// ### hdl/drb_bridge.sv
// Register access bridge to onboard and drive registers with data buffer.
`default_nettype none
module drb_bridge #(
  parameter int ADDR_W = 5,
  parameter int REG_COUNT = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic host_pause,
  output logic device_selected,
  output logic drive_cycle_request,
  output logic write_direction,
  output logic [2:0] unit_select_lines,
  output logic [4:0] register_select_code,
  output logic [15:0] drive_data_out,
  output logic drive_data_oe,
  input wire logic [15:0] drive_data_in,
  input wire logic drive_ack
);

  // Lookup table: {valid, onboard, coded bits, select code}.
  function automatic logic [8:0] drb_lookup(input logic [ADDR_W-1:0] a);
    logic [4:0] idx;
    logic [8:0] res;
    idx = a[4:0];
    res = {1'b0, 1'b0, drb_pkg::CODE_NONE, idx};
    if (idx == drb_pkg::IDX_CS2) begin
      res = {1'b1, 1'b1, drb_pkg::CODE_CS2, idx};
    end else if (idx == drb_pkg::IDX_DB) begin
      res = {1'b1, 1'b1, drb_pkg::CODE_DB, idx};
    end else if (idx == drb_pkg::IDX_DB_DOUBLE) begin
      res = {1'b1, 1'b1, drb_pkg::CODE_DB_DOUBLE, idx};
    end else if (32'(a) < REG_COUNT) begin
      // Any other index below the register count lives in the drive.
      res = {1'b1, 1'b0, drb_pkg::CODE_NONE, idx};
    end
    return res;
  endfunction

  drb_pkg::drb_state_e state_r; // Sequencer state.
  logic [drb_pkg::CNT_W-1:0] cnt_r; // Settle and hold down-counter.
  drb_pkg::drb_cycle_e cycle_r; // Kind of the cycle in progress.
  logic onboard_r; // The cycle targets an onboard register.
  logic valid_r; // The cycle hit a mapped register.
  logic [1:0] code_r; // Coded bits of the onboard register.
  logic [31:0] wdata_r; // Write data held for the done edge.
  logic [2:0] cs2_unit_r; // Drive unit number programmed by software.
  logic ack_meta_r; // First synchroniser stage for the drive ack.
  logic ack_s_r; // Synchronised drive ack.
  logic [15:0] din_meta_r; // First synchroniser stage for drive data.
  logic [15:0] din_s_r; // Synchronised drive data.
  logic [15:0] buf_data_r [drb_pkg::STAGES]; // Buffer stage words.
  logic [drb_pkg::STAGES-1:0] full_r; // Per-stage full flags.
  logic in_ptr_r; // input_side_pointer: 0 even, 1 odd.
  logic mid_ptr_r; // middle_side_pointer: 0 even, 1 odd.
  logic mrg_ptr_r; // merge_source_pointer: 0 even, 1 odd.
  logic [8:0] lk; // Current lookup table output.
  logic [31:0] internal_read_bus; // Onboard register read value.
  logic take, settle_done, ack_seen, hold_done, answer, done;
  logic loc_wr, loc_rd, buf_wr, buf_wr2, buf_rd, buf_rd2, flush;
  logic mv_mid, mv_mrg, mv_r1, mv_r2, mv_out;
  logic is_write; // The new request is a write.

  // Request decode. The bus has no pause line of its own, so a locked
  // read is flagged by host_pause and then handled like a plain read.
  assign is_write = avs_write;
  assign take = (state_r == drb_pkg::ST_IDLE) && (avs_read || avs_write);
  assign lk = drb_lookup(avs_address);
  assign settle_done = (state_r == drb_pkg::ST_SETTLE) && (cnt_r == '0);
  assign ack_seen = (state_r == drb_pkg::ST_DRIVE_WAIT) && ack_s_r;
  assign hold_done = (state_r == drb_pkg::ST_READ_HOLD) && (cnt_r == '0);
  assign done = (state_r == drb_pkg::ST_DONE);
  // The answer is given for onboard or unmapped access at once, for a
  // drive write on its ack, and for a drive read after the hold time.
  assign answer = (take && (!lk[8] || lk[7])) ||
                  (ack_seen && (cycle_r == drb_pkg::CYC_WRITE)) ||
                  hold_done;

  // Onboard effects all land on the done edge, where the master samples.
  assign loc_wr = done && valid_r && onboard_r &&
                  (cycle_r == drb_pkg::CYC_WRITE);
  assign loc_rd = done && valid_r && onboard_r &&
                  (cycle_r != drb_pkg::CYC_WRITE);
  assign buf_wr = loc_wr && (code_r == drb_pkg::CODE_DB);
  assign buf_wr2 = loc_wr && (code_r == drb_pkg::CODE_DB_DOUBLE);
  assign buf_rd = loc_rd && (code_r == drb_pkg::CODE_DB);
  assign buf_rd2 = loc_rd && (code_r == drb_pkg::CODE_DB_DOUBLE);
  assign flush = loc_wr && (code_r == drb_pkg::CODE_CS2) &&
                 wdata_r[drb_pkg::CS2_FLUSH_BIT];

  // Onboard register read value; the flush bit reads back as zero.
  always_comb begin
    internal_read_bus = 32'h0000_0000;
    if (lk[6:5] == drb_pkg::CODE_CS2) begin
      internal_read_bus[drb_pkg::CS2_UNIT_LSB +: drb_pkg::CS2_UNIT_W] =
        cs2_unit_r;
      // Input ready is the empty state of the stage the pointer selects.
      internal_read_bus[drb_pkg::CS2_IR_BIT] =
        !full_r[drb_pkg::STG_IN_EVEN + int'(in_ptr_r)];
      internal_read_bus[drb_pkg::CS2_OR_BIT] =
        full_r[drb_pkg::STG_OUT];
    end else if (lk[6:5] == drb_pkg::CODE_DB) begin
      internal_read_bus[15:0] = buf_data_r[drb_pkg::STG_OUT];
    end else if (lk[6:5] == drb_pkg::CODE_DB_DOUBLE) begin
      // First-loaded word in the low half, its successor in the high.
      internal_read_bus = {buf_data_r[drb_pkg::STG_RIPPLE2],
                           buf_data_r[drb_pkg::STG_OUT]};
    end
  end

  // Stage moves, judged on this cycle's flags only. A stage that
  // receives is empty and so cannot also send, which keeps the
  // ripple free of races at the cost of one clock per stage.
  assign mv_mid = full_r[drb_pkg::STG_IN_EVEN + int'(mid_ptr_r)] &&
                  !full_r[drb_pkg::STG_MID_EVEN + int'(mid_ptr_r)];
  assign mv_mrg = full_r[drb_pkg::STG_MID_EVEN + int'(mrg_ptr_r)] &&
                  !full_r[drb_pkg::STG_MERGE];
  assign mv_r1 = full_r[drb_pkg::STG_MERGE] &&
                 !full_r[drb_pkg::STG_RIPPLE1];
  assign mv_r2 = full_r[drb_pkg::STG_RIPPLE1] &&
                 !full_r[drb_pkg::STG_RIPPLE2];
  assign mv_out = full_r[drb_pkg::STG_RIPPLE2] &&
                  !full_r[drb_pkg::STG_OUT];

  // Two-flop synchronisers for everything arriving from the drive.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_meta_r <= 1'b0;
      ack_s_r <= 1'b0;
      din_meta_r <= 16'h0000;
      din_s_r <= 16'h0000;
    end else begin
      ack_meta_r <= drive_ack;
      ack_s_r <= ack_meta_r;
      din_meta_r <= drive_data_in;
      din_s_r <= din_meta_r;
    end
  end

  // Sequencer and its down-counter.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= drb_pkg::ST_IDLE;
      cnt_r <= '0;
    end else begin
      unique case (state_r)
        drb_pkg::ST_IDLE: begin
          if (take) begin
            if (lk[8] && !lk[7]) begin
              // Drive register: let lines settle before the request.
              cnt_r <= drb_pkg::CNT_W'(drb_pkg::SETTLE_CYC - 1);
              state_r <= drb_pkg::ST_SETTLE;
            end else begin
              state_r <= drb_pkg::ST_DONE;
            end
          end
        end
        drb_pkg::ST_SETTLE: begin
          if (cnt_r == '0) begin
            state_r <= drb_pkg::ST_DRIVE_WAIT;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        drb_pkg::ST_DRIVE_WAIT: begin
          // The drive raises its ack only after finishing the access.
          if (ack_s_r) begin
            if (cycle_r == drb_pkg::CYC_WRITE) begin
              state_r <= drb_pkg::ST_DONE;
            end else begin
              cnt_r <= drb_pkg::CNT_W'(drb_pkg::READ_HOLD_CYC - 1);
              state_r <= drb_pkg::ST_READ_HOLD;
            end
          end
        end
        drb_pkg::ST_READ_HOLD: begin
          if (cnt_r == '0) begin
            state_r <= drb_pkg::ST_DONE;
          end else begin
            cnt_r <= cnt_r - 1'b1;
          end
        end
        drb_pkg::ST_DONE: begin
          // The master releases after this edge; a drive cycle must
          // still see its ack fall before the next one may start.
          if (valid_r && !onboard_r) begin
            state_r <= drb_pkg::ST_RELEASE;
          end else begin
            state_r <= drb_pkg::ST_IDLE;
          end
        end
        drb_pkg::ST_RELEASE: begin
          if (!ack_s_r) begin
            state_r <= drb_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Attributes of the cycle, caught when the request is taken.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cycle_r <= drb_pkg::CYC_READ;
      onboard_r <= 1'b0;
      valid_r <= 1'b0;
      code_r <= drb_pkg::CODE_NONE;
      wdata_r <= 32'h0000_0000;
    end else if (take) begin
      if (is_write) begin
        cycle_r <= drb_pkg::CYC_WRITE;
      end else if (host_pause) begin
        cycle_r <= drb_pkg::CYC_READ_PAUSE;
      end else begin
        cycle_r <= drb_pkg::CYC_READ;
      end
      valid_r <= lk[8];
      onboard_r <= lk[7];
      code_r <= lk[6:5];
      wdata_r <= avs_writedata;
    end
  end

  // Bus answer. Waitrequest stays high except for the one answer cycle.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !answer;
      if (take && lk[8] && lk[7]) begin
        avs_readdata <= internal_read_bus;
      end else if (take && !lk[8]) begin
        // Unmapped index: reads zero, writes are dropped.
        avs_readdata <= 32'h0000_0000;
      end else if (hold_done) begin
        avs_readdata <= {16'h0000, din_s_r};
      end
    end
  end

  // Drive bus outputs for a remote register cycle.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      device_selected <= 1'b0;
      drive_cycle_request <= 1'b0;
      write_direction <= 1'b0;
      register_select_code <= 5'h00;
      drive_data_out <= 16'h0000;
      drive_data_oe <= 1'b0;
    end else if (take && lk[8] && !lk[7]) begin
      device_selected <= 1'b1;
      register_select_code <= lk[4:0];
      write_direction <= is_write;
      drive_data_out <= avs_writedata[15:0];
      drive_data_oe <= is_write;
    end else if (settle_done) begin
      drive_cycle_request <= 1'b1;
    end else if (done) begin
      // Release the drive together with the host answer.
      device_selected <= 1'b0;
      drive_cycle_request <= 1'b0;
      write_direction <= 1'b0;
      drive_data_oe <= 1'b0;
    end
  end

  // Unit number register; it drives the unit select lines directly.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cs2_unit_r <= drb_pkg::CS2_UNIT_RST;
    end else if (loc_wr && (code_r == drb_pkg::CODE_CS2)) begin
      cs2_unit_r <=
        wdata_r[drb_pkg::CS2_UNIT_LSB +: drb_pkg::CS2_UNIT_W];
    end
  end
  assign unit_select_lines = cs2_unit_r;

  // Steering pointers. A double write fills both sides, so the input
  // pointer comes back to where it started.
  always_ff @(posedge clk_sys) begin
    if (rst || flush) begin
      in_ptr_r <= 1'b0;
      mid_ptr_r <= 1'b0;
      mrg_ptr_r <= 1'b0;
    end else begin
      if (buf_wr) begin
        in_ptr_r <= !in_ptr_r;
      end
      if (mv_mid) begin
        mid_ptr_r <= !mid_ptr_r;
      end
      if (mv_mrg) begin
        mrg_ptr_r <= !mrg_ptr_r;
      end
    end
  end

  // Stage flags. Write sets win over move clears, and read clears win over move sets, in the same cycle.
  // There is no overflow guard: a write to a full input stage simply
  // replaces its word, so software must watch input ready.
  always_ff @(posedge clk_sys) begin
    if (rst || flush) begin
      full_r <= '0;
    end else begin
      for (int i = 0; i < drb_pkg::STAGES; i++) begin
        full_r[i] <= full_r[i];
      end
      if (mv_mid) begin
        full_r[drb_pkg::STG_IN_EVEN + int'(mid_ptr_r)] <= 1'b0;
        full_r[drb_pkg::STG_MID_EVEN + int'(mid_ptr_r)] <= 1'b1;
      end
      if (mv_mrg) begin
        full_r[drb_pkg::STG_MID_EVEN + int'(mrg_ptr_r)] <= 1'b0;
        full_r[drb_pkg::STG_MERGE] <= 1'b1;
      end
      if (mv_r1) begin
        full_r[drb_pkg::STG_MERGE] <= 1'b0;
        full_r[drb_pkg::STG_RIPPLE1] <= 1'b1;
      end
      if (mv_r2) begin
        full_r[drb_pkg::STG_RIPPLE1] <= 1'b0;
        full_r[drb_pkg::STG_RIPPLE2] <= 1'b1;
      end
      if (mv_out) begin
        full_r[drb_pkg::STG_RIPPLE2] <= 1'b0;
        full_r[drb_pkg::STG_OUT] <= 1'b1;
      end
      if (buf_rd) begin
        full_r[drb_pkg::STG_OUT] <= 1'b0;
      end
      if (buf_rd2) begin
        full_r[drb_pkg::STG_OUT] <= 1'b0;
        full_r[drb_pkg::STG_RIPPLE2] <= 1'b0;
      end
      if (buf_wr) begin
        full_r[drb_pkg::STG_IN_EVEN + int'(in_ptr_r)] <= 1'b1;
      end
      if (buf_wr2) begin
        full_r[drb_pkg::STG_IN_EVEN] <= 1'b1;
        full_r[drb_pkg::STG_IN_ODD] <= 1'b1;
      end
    end
  end

  // Stage words. Each move copies in one clock; no reset is needed on
  // data because the flags say which words count.
  always_ff @(posedge clk_sys) begin
    if (mv_mid) begin
      buf_data_r[drb_pkg::STG_MID_EVEN + int'(mid_ptr_r)] <=
        buf_data_r[drb_pkg::STG_IN_EVEN + int'(mid_ptr_r)];
    end
    if (mv_mrg) begin
      buf_data_r[drb_pkg::STG_MERGE] <=
        buf_data_r[drb_pkg::STG_MID_EVEN + int'(mrg_ptr_r)];
    end
    if (mv_r1) begin
      buf_data_r[drb_pkg::STG_RIPPLE1] <= buf_data_r[drb_pkg::STG_MERGE];
    end
    if (mv_r2) begin
      buf_data_r[drb_pkg::STG_RIPPLE2] <= buf_data_r[drb_pkg::STG_RIPPLE1];
    end
    if (mv_out) begin
      buf_data_r[drb_pkg::STG_OUT] <= buf_data_r[drb_pkg::STG_RIPPLE2];
    end
    if (buf_wr) begin
      buf_data_r[drb_pkg::STG_IN_EVEN + int'(in_ptr_r)] <=
        wdata_r[15:0];
    end
    if (buf_wr2) begin
      // The low half goes in first, so it must land on the side the
      // middle pointer will serve first after an even start.
      buf_data_r[drb_pkg::STG_IN_EVEN + int'(in_ptr_r)] <=
        wdata_r[15:0];
      buf_data_r[drb_pkg::STG_IN_EVEN + int'(!in_ptr_r)] <=
        wdata_r[31:16];
    end
  end

endmodule
`default_nettype wire

// ### testbench/drb_checker.sv
// Port-level checks of the drive register bridge and data buffer.
`default_nettype none
module drb_checker #(
  parameter int ADDR_W = 5,
  parameter int REG_COUNT = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic host_pause,
  input wire logic device_selected,
  input wire logic drive_cycle_request,
  input wire logic write_direction,
  input wire logic [2:0] unit_select_lines,
  input wire logic [4:0] register_select_code,
  input wire logic [15:0] drive_data_out,
  input wire logic drive_data_oe,
  input wire logic [15:0] drive_data_in,
  input wire logic drive_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Unit number last written by software, tracked at the write edge.
  logic [2:0] unit_r;
  // Mirrors the unit field so the unit lines can be judged.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      unit_r <= drb_pkg::CS2_UNIT_RST;
    end else if (avs_write && !avs_waitrequest &&
        avs_address == drb_pkg::IDX_CS2) begin
      unit_r <= avs_writedata[2:0];
    end
  end
  // Three quiet cycles let the lines settle before the request.
  sequence s_settle;
    (!drive_cycle_request) [*3] ##1 drive_cycle_request;
  endsequence
  // A drive read answer is held back so its data is settled.
  sequence s_read_hold;
    avs_waitrequest [*3] ##[1:4] !avs_waitrequest;
  endsequence
  property p_settle;
    $rose(device_selected) |-> s_settle;
  endproperty
  a_settle: assert property (p_settle) else $error("request too early");
  property p_write_ack;
    $rose(drive_ack) && write_direction |-> ##[1:3] !avs_waitrequest;
  endproperty
  a_write_ack: assert property (p_write_ack) else $error("late answer");
  property p_read_hold;
    $rose(drive_ack) && device_selected && !write_direction |-> s_read_hold;
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read hold");
  property p_release;
    !avs_waitrequest && device_selected |=> avs_waitrequest &&
      !device_selected && !drive_cycle_request && !drive_data_oe;
  endproperty
  a_release: assert property (p_release) else $error("no release");
  property p_onboard;
    $rose(avs_read) && avs_address == drb_pkg::IDX_CS2 |->
      ##[1:6] (!avs_waitrequest && avs_readdata[31:8] == 24'h000000);
  endproperty
  a_onboard: assert property (p_onboard) else $error("onboard read");
  property p_unit;
    device_selected |-> unit_select_lines == unit_r;
  endproperty
  a_unit: assert property (p_unit) else $error("wrong unit");
  property p_wdata;
    device_selected && write_direction && avs_write |-> drive_data_oe &&
      drive_data_out == avs_writedata[15:0] &&
      register_select_code == avs_address[4:0];
  endproperty
  a_wdata: assert property (p_wdata) else $error("write data");
  property p_rdata;
    !avs_waitrequest && device_selected && !write_direction |->
      avs_readdata == {16'h0000, drive_data_in};
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data");
endmodule
bind drb_bridge drb_checker #(.ADDR_W(ADDR_W), .REG_COUNT(REG_COUNT))
  u_drb_checker (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .host_pause(host_pause),
  .device_selected(device_selected),
  .drive_cycle_request(drive_cycle_request),
  .write_direction(write_direction), .unit_select_lines(unit_select_lines),
  .register_select_code(register_select_code),
  .drive_data_out(drive_data_out), .drive_data_oe(drive_data_oe),
  .drive_data_in(drive_data_in), .drive_ack(drive_ack));
`default_nettype wire

// ### testbench/drb_drive_model.sv
// Behavioural model of one drive on the shared drive bus.
`default_nettype none
module drb_drive_model #(
  parameter logic [2:0] MY_UNIT = 3'h2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic drive_cycle_request,
  input wire logic write_direction,
  input wire logic [2:0] unit_select_lines,
  input wire logic [4:0] register_select_code,
  input wire logic [15:0] drive_data_out,
  input wire logic [3:0] ack_delay,
  output logic [15:0] drive_data_in,
  output logic drive_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] regs_r [0:31]; // Registers inside the drive.
  logic [3:0] wait_r; // Cycles left before the drive answers.
  logic [15:0] last_r; // Last word the drive put on the lines.
  logic drive_en_r; // High while the drive owns the data lines.
  logic hit; // Request seen with this drive's own unit number.
  assign hit = drive_cycle_request && unit_select_lines == MY_UNIT;
  // Released lines show the inverse so stale data never looks valid.
  assign drive_data_in = drive_en_r ? last_r : ~last_r;
  // Access sequencing; a slow drive waits ack_delay cycles first.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      drive_ack <= 1'b0;
      drive_en_r <= 1'b0;
      wait_r <= 4'h0;
      last_r <= 16'h0000;
    end else if (!hit) begin
      drive_ack <= 1'b0;
      drive_en_r <= 1'b0;
      wait_r <= ack_delay;
    end else if (wait_r != 4'h0) begin
      wait_r <= wait_r - 4'h1;
    end else if (!drive_ack) begin
      drive_ack <= 1'b1;
      if (write_direction) begin
        regs_r[register_select_code] <= drive_data_out;
      end else begin
        drive_en_r <= 1'b1;
        last_r <= regs_r[register_select_code];
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/drive_reg_access_and_data_buffer_test.sv
// Self-checking bench for the drive register bridge and data buffer.
`default_nettype none
`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin \
  n_errors++; $display("mismatch %s expected %h seen %h", what, exp, got); \
  end end
module drive_reg_access_and_data_buffer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0; // System clock, 100 ns period.
  logic rst = 1'b1; // Synchronous reset, active high.
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic host_pause = 1'b0;
  logic [3:0] ack_delay = 4'h0; // Answer delay of the drive model.
  wire [31:0] avs_readdata;
  wire avs_waitrequest, drive_cycle_request, write_direction, drive_ack;
  wire [2:0] unit_select_lines;
  wire [4:0] register_select_code;
  wire [15:0] drive_data_out, drive_data_in;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  drb_bridge u_drb_bridge (.clk_sys(clk_sys), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .host_pause(host_pause),
    .device_selected(), .drive_cycle_request(drive_cycle_request),
    .write_direction(write_direction), .unit_select_lines(unit_select_lines),
    .register_select_code(register_select_code),
    .drive_data_out(drive_data_out), .drive_data_oe(),
    .drive_data_in(drive_data_in), .drive_ack(drive_ack));
  drb_drive_model #(.MY_UNIT(3'h2)) u_drb_drive_model (.clk_sys(clk_sys),
    .rst(rst), .drive_cycle_request(drive_cycle_request),
    .write_direction(write_direction), .unit_select_lines(unit_select_lines),
    .register_select_code(register_select_code),
    .drive_data_out(drive_data_out), .ack_delay(ack_delay),
    .drive_data_in(drive_data_in), .drive_ack(drive_ack));
  // Clock toggles every half period.
  always #50 clk_sys = ~clk_sys;
  // Prints the counts and the verdict, then stops the run.
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // A hung handshake would stall forever, so a cycle ceiling cuts it.
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_errors++;
      $display("mismatch timeout expected %0d seen %0d", 0, cycles);
      wrap_up;
    end
  end
  // Avalon write held until waitrequest is sampled low.
  task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    avs_write <= 1'b0;
  endtask
  // Avalon read; data is taken at the edge that sees waitrequest low.
  task automatic bus_rd(input logic [4:0] a, input logic p,
      output logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    host_pause <= p;
    avs_read <= 1'b1;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    d = avs_readdata;
    avs_read <= 1'b0;
    host_pause <= 1'b0;
  endtask
  // Reads one register and compares it with the expected word.
  task automatic rd_chk(input string what, input logic [4:0] a,
      input logic [31:0] exp);
    logic [31:0] got;
    bus_rd(a, 1'b0, got);
    `CHK(what, exp, got)
  endtask
  // Status after reset, and a write and read of an unmapped index.
  task automatic t_reset;
    rd_chk("cs2 reset", drb_pkg::IDX_CS2, 32'h00000040);
    bus_wr(5'h14, 32'hFFFFFFFF);
    rd_chk("unmapped", 5'h14, 32'h00000000);
    $display("test reset done");
  endtask
  // Drive register writes and reads, prompt and slow drive answers.
  task automatic t_drive;
    logic [31:0] got;
    bus_wr(drb_pkg::IDX_CS2, 32'h00000002);
    bus_wr(5'h01, 32'hFFFFA5C3);
    ack_delay <= 4'h5;
    bus_wr(5'h03, 32'h00005A3C);
    rd_chk("drive reg", 5'h01, 32'h0000A5C3);
    bus_rd(5'h03, 1'b1, got);
    `CHK("paused read", 32'h00005A3C, got)
    ack_delay <= 4'h0;
    rd_chk("cs2 unit", drb_pkg::IDX_CS2, 32'h00000042);
    $display("test drive done");
  endtask
  // Fill to full, overwrite with a ninth word, then drain in order.
  task automatic t_fill;
    int unsigned seq [8] = '{1, 2, 3, 4, 5, 6, 9, 8};
    bus_wr(drb_pkg::IDX_CS2, 32'h00000022);
    for (int i = 1; i <= 8; i++) bus_wr(drb_pkg::IDX_DB, 32'hC000 + i);
    repeat (10) @(posedge clk_sys);
    rd_chk("cs2 full", drb_pkg::IDX_CS2, 32'h00000082);
    bus_wr(drb_pkg::IDX_DB, 32'h0000C009);
    repeat (4) @(posedge clk_sys);
    rd_chk("cs2 ninth", drb_pkg::IDX_CS2, 32'h00000082);
    for (int j = 0; j < 8; j++) begin
      rd_chk("fifo word", drb_pkg::IDX_DB, 32'hC000 + seq[j]);
    end
    rd_chk("cs2 drained", drb_pkg::IDX_CS2, 32'h00000042);
    $display("test fill done");
  endtask
  // Flush with words inside, single timing, double word split.
  task automatic t_double;
    bus_wr(drb_pkg::IDX_DB, 32'h00000777);
    bus_wr(drb_pkg::IDX_DB, 32'h00000888);
    bus_wr(drb_pkg::IDX_CS2, 32'h00000022);
    rd_chk("cs2 flushed", drb_pkg::IDX_CS2, 32'h00000042);
    bus_wr(drb_pkg::IDX_DB, 32'h00001234);
    repeat (4) @(posedge clk_sys);
    rd_chk("one word", drb_pkg::IDX_CS2, 32'h000000C2);
    bus_wr(drb_pkg::IDX_DB_DOUBLE, 32'hBBBBAAAA);
    repeat (8) @(posedge clk_sys);
    rd_chk("single", drb_pkg::IDX_DB, 32'h00001234);
    rd_chk("double lo", drb_pkg::IDX_DB, 32'h0000AAAA);
    rd_chk("double hi", drb_pkg::IDX_DB, 32'h0000BBBB);
    bus_wr(drb_pkg::IDX_DB_DOUBLE, 32'hDDDDCCCC);
    repeat (8) @(posedge clk_sys);
    rd_chk("double rd", drb_pkg::IDX_DB_DOUBLE, 32'hDDDDCCCC);
    rd_chk("cs2 empty", drb_pkg::IDX_CS2, 32'h00000042);
    $display("test double done");
  endtask
  // Reset for 12 cycles, then the scenarios in turn.
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset;
    t_drive;
    t_fill;
    t_double;
    wrap_up;
  end
endmodule
`default_nettype wire
